// *** hdl/sia_pkg.sv ***
package sia_pkg;

	// Parameter slots on the edit port
	localparam logic [2:0] IDX_IN_A   = 3'h0;
	localparam logic [2:0] IDX_IN_B   = 3'h1;
	localparam logic [2:0] IDX_OUT_A  = 3'h2;
	localparam logic [2:0] IDX_OUT_B  = 3'h3;
	localparam logic [2:0] IDX_OUT_C  = 3'h4;
	localparam logic [2:0] IDX_POL    = 3'h5;
	localparam logic [2:0] IDX_MON_IN = 3'h6;

	// Factory values of the stored allocations
	localparam logic [15:0] RST_IN_A  = 16'h2100;
	localparam logic [15:0] RST_IN_B  = 16'h6543;
	localparam logic [15:0] RST_OUT_A = 16'h3211;
	localparam logic [15:0] RST_OUT_B = 16'h0000;
	localparam logic [15:0] RST_OUT_C = 16'h0000;
	localparam logic [15:0] RST_POL   = 16'h0000;

	// Input code values
	localparam logic [3:0] CODE_TERM_LAST = 4'h6;
	localparam logic [3:0] CODE_ALWAYS_ON = 4'h7;
	localparam logic [3:0] CODE_ALWAYS_OFF = 4'h8;
	localparam logic [3:0] CODE_HIGH_BASE = 4'h9;

	// Output and free-assignment code values
	localparam logic [3:0] CODE_UNUSED    = 4'h0;
	localparam logic [3:0] CODE_INVERT    = 4'h1;
	localparam logic [3:0] CODE_FREE_MAP  = 4'h1;

	// Counts
	localparam int N_IN_TERM  = 7;
	localparam int N_IN_FUNC  = 7;
	localparam int N_OUT_TERM = 3;
	localparam int N_OUT_SIG  = 10;

	// Input function positions (digit index over the two input parameters, counted from the second digit of the first)
	localparam int FN_SERVO_EN   = 0;
	localparam int FN_PROP       = 1;
	localparam int FN_FWD_PROHIB = 2;
	localparam int FN_REV_PROHIB = 3;
	localparam int FN_ALM_RESET  = 4;
	localparam int FN_FWD_TLIM   = 5;
	localparam int FN_REV_TLIM   = 6;

	// Save confirmation flash
	localparam int CLK_MHZ          = 250;
	localparam int FLASH_MS         = 500;
	localparam int FLASH_CYCLES_DEF = FLASH_MS * CLK_MHZ * 1000;

	// Control modes
	typedef enum logic [1:0] {
		SIA_MODE_SPEED,
		SIA_MODE_POSITION,
		SIA_MODE_TORQUE
	} sia_mode_e;

	// Internal status signals offered to the output terminals
	typedef struct packed {
		logic pulseMultAck;
		logic near;
		logic warning;
		logic brakeRelease;
		logic speedLimited;
		logic torqueLimited;
		logic servoReady;
		logic rotating;
		logic speedMatch;
		logic positionDone;
	} sia_status_s;

	// One committed parameter edit
	typedef struct packed {
		logic        we;
		logic [2:0]  idx;
		logic [15:0] data;
	} sia_edit_s;

endpackage

// *** hdl/sia_input_pick.sv ***
// Resolves one input function from its allocation code
module sia_input_pick (
	// Allocation code
	input  wire logic [3:0] code,
	// Terminal ON states after wiring polarity
	input  wire logic [6:0] termOn,
	// Resolved function state
	output logic            fnOn
);

	logic [3:0] highIdx;

	assign highIdx = code - sia_pkg::CODE_HIGH_BASE;

	// Low codes follow the terminal, high codes follow it inverted
	always_comb begin
		if (code <= sia_pkg::CODE_TERM_LAST) begin
			fnOn = termOn[code[2:0]];
		end else if (code == sia_pkg::CODE_ALWAYS_ON) begin
			fnOn = 1'b1;
		end else if (code == sia_pkg::CODE_ALWAYS_OFF) begin
			fnOn = 1'b0;
		end else begin
			fnOn = ~termOn[highIdx[2:0]];
		end
	end

endmodule

// *** hdl/sia_allocator.sv ***
// Notes on behaviour
// - Output digit 1..3 picks pair, 0 unrouted
// - First output parameter: done, match, rotating, ready
// - Second: torque, speed, brake, warning; third: near, ack
// - Shared output terminal drives OR of signals
// - Signals meaningless in current mode are invalid
// - Per-terminal polarity digit, 1 inverts, 0 default
// - Allocation changes apply only after power cycle
// - Input digit zero set to 1 frees assignment
// - Second input digit selects servo-enable terminal
// - Third digit of second selects forward torque limit
// - Sink wiring low is ON, source reversed
// - Committed edit is stored, display flashes
// - Input monitor shows all input signal states
// - Codes 0-6 low, 9-F high, 7 on, 8 off
module sia_allocator #(
	parameter int FLASH_CYCLES = sia_pkg::FLASH_CYCLES_DEF
) (
	// Clock and reset (reset stands for a power cycle)
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic                keepStored,
	// Parameter edit and readback
	input  wire sia_pkg::sia_edit_s  paramEdit,
	input  wire logic [2:0]          paramRdIdx,
	output logic [15:0]              paramRdData_r,
	output logic                     saveFlash_r,
	// Connector input terminals and wiring choice
	input  wire logic [6:0]          inTermPin,
	input  wire logic                sinkWiring,
	// Resolved input functions
	output logic [6:0]               inFunc_r,
	output logic [15:0]              inputStateMonitor_r,
	// Internal status and control mode
	input  wire sia_pkg::sia_status_s statusIn,
	input  wire sia_pkg::sia_mode_e  ctrlMode,
	// Output terminal pairs
	output logic [2:0]               outTerm_r
);

	// Stored (persistent) and active copies of each parameter
	logic [15:0] inA_r, inB_r, outA_r, outB_r, outC_r, pol_r;
	logic [15:0] actInA_r, actInB_r, actOutA_r, actOutB_r, actOutC_r, actPol_r;

	// Synchronised pins
	logic [6:0] pinMeta_r, pinSync_r;
	logic       sinkMeta_r, sinkSync_r;

	// Derived signals
	logic [6:0]  termOn;
	logic [27:0] inCodes;
	logic [27:0] fixedCodes;
	logic [6:0]  fnOn;
	logic [39:0] outCodes;
	logic [9:0]  sigValid;
	logic [2:0]  termOr;
	logic [31:0] flashCnt_r;

	// Persistent store; survives reset unless factory values are requested
	always_ff @(posedge sys_clk) begin
		if (sys_rst && !keepStored) begin
			inA_r  <= sia_pkg::RST_IN_A;
			inB_r  <= sia_pkg::RST_IN_B;
			outA_r <= sia_pkg::RST_OUT_A;
			outB_r <= sia_pkg::RST_OUT_B;
			outC_r <= sia_pkg::RST_OUT_C;
			pol_r  <= sia_pkg::RST_POL;
		end else if (!sys_rst && paramEdit.we) begin
			case (paramEdit.idx)
				sia_pkg::IDX_IN_A:  inA_r  <= paramEdit.data;
				sia_pkg::IDX_IN_B:  inB_r  <= paramEdit.data;
				sia_pkg::IDX_OUT_A: outA_r <= paramEdit.data;
				sia_pkg::IDX_OUT_B: outB_r <= paramEdit.data;
				sia_pkg::IDX_OUT_C: outC_r <= paramEdit.data;
				sia_pkg::IDX_POL:   pol_r  <= paramEdit.data;
				default: ;
			endcase
		end
	end

	// Active routing is copied from the store only at power-up
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			actInA_r  <= keepStored ? inA_r  : sia_pkg::RST_IN_A;
			actInB_r  <= keepStored ? inB_r  : sia_pkg::RST_IN_B;
			actOutA_r <= keepStored ? outA_r : sia_pkg::RST_OUT_A;
			actOutB_r <= keepStored ? outB_r : sia_pkg::RST_OUT_B;
			actOutC_r <= keepStored ? outC_r : sia_pkg::RST_OUT_C;
			actPol_r  <= keepStored ? pol_r  : sia_pkg::RST_POL;
		end
	end

	// Save confirmation flash, restarted by each commit to a stored slot (IDX_IN_A..IDX_POL)
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			flashCnt_r  <= 32'h0000_0000;
			saveFlash_r <= 1'b0;
		end else if (paramEdit.we && paramEdit.idx <= sia_pkg::IDX_POL) begin
			flashCnt_r  <= 32'(FLASH_CYCLES - 1);
			saveFlash_r <= 1'b1;
		end else if (flashCnt_r != 32'h0000_0000) begin
			flashCnt_r  <= flashCnt_r - 32'h0000_0001;
		end else begin
			saveFlash_r <= 1'b0;
		end
	end

	// Two-flop synchronisers for the connector pins
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pinMeta_r  <= 7'h7F; // Open contacts on sink wiring read OFF
			pinSync_r  <= 7'h7F;
			sinkMeta_r <= 1'b1;
			sinkSync_r <= 1'b1;
		end else begin
			pinMeta_r  <= inTermPin;
			pinSync_r  <= pinMeta_r;
			sinkMeta_r <= sinkWiring;
			sinkSync_r <= sinkMeta_r;
		end
	end

	// Terminal ON state from wiring type
	assign termOn = sinkSync_r ? ~pinSync_r : pinSync_r;

	// Free assignment uses the active codes, otherwise the factory map
	assign fixedCodes = {sia_pkg::RST_IN_B, sia_pkg::RST_IN_A[15:4]};
	assign inCodes    = (actInA_r[3:0] == sia_pkg::CODE_FREE_MAP) ?
		{actInB_r, actInA_r[15:4]} : fixedCodes;

	// One code resolver per input function
	genvar gi;
	generate
		for (gi = 0; gi < sia_pkg::N_IN_FUNC; gi++) begin : g_in
			sia_input_pick u_pick (
				.code   (inCodes[gi*4 +: 4]),
				.termOn (termOn),
				.fnOn   (fnOn[gi])
			);
		end
	endgenerate

	// Registered input functions and monitor image
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			inFunc_r            <= 7'h00;
			inputStateMonitor_r <= 16'h0000;
		end else begin
			inFunc_r            <= fnOn;
			inputStateMonitor_r <= {2'h0, fnOn, termOn};
		end
	end

	// Output digits in status order: a0..a3, b0..b3, c0, c2
	assign outCodes = {actOutC_r[11:8], actOutC_r[3:0], actOutB_r, actOutA_r};

	// Mode gating: only meaningful status may drive a terminal
	always_comb begin
		sigValid = statusIn;
		case (ctrlMode)
			sia_pkg::SIA_MODE_POSITION: begin
				sigValid[1] = 1'b0;
				sigValid[5] = 1'b0;
			end
			sia_pkg::SIA_MODE_SPEED: begin
				sigValid[0] = 1'b0;
				sigValid[8] = 1'b0;
				sigValid[5] = 1'b0;
			end
			sia_pkg::SIA_MODE_TORQUE: begin
				sigValid[0] = 1'b0;
				sigValid[1] = 1'b0;
				sigValid[8] = 1'b0;
			end
			default: sigValid = 10'h000;
		endcase
	end

	// OR of every valid signal routed to each terminal pair
	genvar gt;
	generate
		for (gt = 0; gt < sia_pkg::N_OUT_TERM; gt++) begin : g_out
			logic [9:0] hit;
			for (genvar gs = 0; gs < sia_pkg::N_OUT_SIG; gs++) begin : g_sig
				assign hit[gs] = sigValid[gs] && (outCodes[gs*4 +: 4] == 4'(gt + 1));
			end
			assign termOr[gt] = |hit;
			// Polarity applied last, so an empty terminal rests at its inactive level
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					outTerm_r[gt] <= 1'b0;
				end else begin
					outTerm_r[gt] <= termOr[gt] ^ (actPol_r[gt*4 +: 4] == sia_pkg::CODE_INVERT);
				end
			end
		end
	endgenerate

	// Parameter readback, one cycle after the index
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			paramRdData_r <= 16'h0000;
		end else begin
			case (paramRdIdx)
				sia_pkg::IDX_IN_A:   paramRdData_r <= inA_r;
				sia_pkg::IDX_IN_B:   paramRdData_r <= inB_r;
				sia_pkg::IDX_OUT_A:  paramRdData_r <= outA_r;
				sia_pkg::IDX_OUT_B:  paramRdData_r <= outB_r;
				sia_pkg::IDX_OUT_C:  paramRdData_r <= outC_r;
				sia_pkg::IDX_POL:    paramRdData_r <= pol_r;
				sia_pkg::IDX_MON_IN: paramRdData_r <= inputStateMonitor_r;
				default:             paramRdData_r <= 16'h0000;
			endcase
		end
	end

endmodule

// *** verification/sia_allocator_monitor.sv ***
module sia_allocator_monitor #(
	parameter int FLASH_CYCLES = 8
) (
	// Clock and reset
	input wire logic               sys_clk,
	input wire logic               sys_rst,
	// Edit and readback
	input wire sia_pkg::sia_edit_s paramEdit,
	input wire logic [2:0]         paramRdIdx,
	input wire logic [15:0]        paramRdData_r,
	input wire logic               saveFlash_r,
	// Input side
	input wire logic [6:0]         inTermPin,
	input wire logic               sinkWiring,
	input wire logic [6:0]         inFunc_r,
	input wire logic [15:0]        inputStateMonitor_r,
	// Output side
	input wire sia_pkg::sia_status_s statusIn,
	input wire sia_pkg::sia_mode_e ctrlMode,
	input wire logic [2:0]         outTerm_r
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Save flash
	flash_rise_a: assert property (paramEdit.we && paramEdit.idx <= 3'h5 |=> saveFlash_r)
		else $error("flash missing after commit");
	flash_len_a: assert property ($rose(saveFlash_r) |-> saveFlash_r[*8])
		else $error("flash too short");
	flash_idle_a: assert property (!saveFlash_r && !(paramEdit.we && paramEdit.idx <= 3'h5) |=> !saveFlash_r)
		else $error("flash without commit");
	// Reset and readback
	rst_clear_a: assert property ($fell(sys_rst) |-> outTerm_r == 3'h0 && inFunc_r == 7'h00 && !saveFlash_r)
		else $error("outputs not cleared by reset");
	rd_zero_a: assert property (paramRdIdx == 3'h7 |=> paramRdData_r == 16'h0000)
		else $error("empty slot not zero");
	// Input monitor
	mon_pack_a: assert property (inputStateMonitor_r[15:7] == {2'h0, inFunc_r})
		else $error("monitor packing wrong");
	term_on_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
		|-> inputStateMonitor_r[6:0] == ($past(sinkWiring, 3) ? ~$past(inTermPin, 3) : $past(inTermPin, 3)))
		else $error("terminal state wrong");
	// Routing only moves with its causes
	out_hold_a: assert property ($stable(statusIn) && $stable(ctrlMode) && !$past(sys_rst) |=> $stable(outTerm_r))
		else $error("output moved without cause");
	in_hold_a: assert property ($stable(inputStateMonitor_r[6:0]) && !$past(sys_rst) && !$past(sys_rst, 2)
		|-> $stable(inFunc_r))
		else $error("function moved without cause");

	// Main scenarios
	cover property (saveFlash_r);
	cover property (outTerm_r == 3'h5);
	cover property (inFunc_r[0]);
endmodule

// *** verification/sia_field_model.sv ***
module sia_field_model (
	// Wanted contact states and wiring
	input wire logic [6:0] termOn,
	input wire logic       sink,
	// Terminal pin levels
	output logic [6:0]     pins
);
	timeunit 1ns;
	timeprecision 1ps;

	// Closed contact pulls low on sink, high on source
	always_comb pins = sink ? ~termOn : termOn;
endmodule

// *** verification/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 sys_clk, sys_rst, keepStored, sinkWiring, saveFlash_r;
	sia_pkg::sia_edit_s   paramEdit;
	logic [2:0]           paramRdIdx, outTerm_r;
	logic [15:0]          paramRdData_r, inputStateMonitor_r;
	logic [6:0]           inTermPin, inFunc_r, onReq;
	sia_pkg::sia_status_s statusIn;
	sia_pkg::sia_mode_e   ctrlMode;
	logic [15:0]          fac [8] = '{16'h2100, 16'h6543, 16'h3211, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
	int                   error_cnt, checks;

	`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
		$display("unexpected %s exp %h got %h", n, e, g); end end

	sia_allocator #(.FLASH_CYCLES(8)) dut (.sys_clk, .sys_rst, .keepStored, .paramEdit, .paramRdIdx,
		.paramRdData_r, .saveFlash_r, .inTermPin, .sinkWiring, .inFunc_r, .inputStateMonitor_r,
		.statusIn, .ctrlMode, .outTerm_r);
	sia_field_model field (.termOn(onReq), .sink(sinkWiring), .pins(inTermPin));

	// Clock
	initial begin
		sys_clk = 0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Power cycle
	task pw(input logic k);
		@(negedge sys_clk);
		sys_rst = 1;
		keepStored = k;
		repeat (8) @(negedge sys_clk);
		sys_rst = 0;
		repeat (4) @(negedge sys_clk);
	endtask

	// Commit one value, check flash and stored copy
	task ed(input logic [2:0] i, input logic [15:0] d);
		@(negedge sys_clk);
		paramEdit = '{1'b1, i, d};
		paramRdIdx = i;
		@(negedge sys_clk);
		paramEdit.we = 0;
		`CHK("flash", 1'b1, saveFlash_r)
		@(negedge sys_clk);
		`CHK("stored", d, paramRdData_r)
	endtask

	// Status to output terminals
	task st(input sia_pkg::sia_mode_e m, input logic [9:0] s, input logic [2:0] e);
		@(negedge sys_clk);
		ctrlMode = m;
		statusIn = s;
		@(negedge sys_clk);
		`CHK("outTerm", e, outTerm_r)
	endtask

	// Contacts to input functions
	task fi(input logic sk, input logic [6:0] on, input logic [6:0] e);
		@(negedge sys_clk);
		sinkWiring = sk;
		onReq = on;
		repeat (5) @(negedge sys_clk);
		`CHK("inFunc", e, inFunc_r)
	endtask

	task conclude;
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		#20000;
		error_cnt++;
		conclude;
	end

	// Main sequence
	initial begin
		{keepStored, sinkWiring, paramEdit, paramRdIdx, onReq, statusIn} = '0;
		sys_rst = 1'b1;
		ctrlMode = sia_pkg::SIA_MODE_SPEED;
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			@(negedge sys_clk);
			paramRdIdx = i[2:0];
			@(negedge sys_clk);
			if (i != 6) `CHK("factory", fac[i], paramRdData_r)
		end
		st(sia_pkg::SIA_MODE_POSITION, 10'h001, 3'h1);
		st(sia_pkg::SIA_MODE_POSITION, 10'h002, 3'h0);
		st(sia_pkg::SIA_MODE_SPEED, 10'h003, 3'h1);
		st(sia_pkg::SIA_MODE_SPEED, 10'h001, 3'h0);
		st(sia_pkg::SIA_MODE_TORQUE, 10'h00C, 3'h6);
		st(sia_pkg::SIA_MODE_TORQUE, 10'h3F0, 3'h0);
		ed(sia_pkg::IDX_OUT_A, 16'h3011);
		ed(sia_pkg::IDX_OUT_B, 16'h0200);
		ed(sia_pkg::IDX_OUT_C, 16'h2003);
		ed(sia_pkg::IDX_POL, 16'h0001); // Brake pair left uninverted
		st(sia_pkg::SIA_MODE_TORQUE, 10'h004, 3'h2);
		pw(1);
		st(sia_pkg::SIA_MODE_POSITION, 10'h000, 3'h1);
		st(sia_pkg::SIA_MODE_POSITION, 10'h005, 3'h0);
		st(sia_pkg::SIA_MODE_POSITION, 10'h240, 3'h3);
		st(sia_pkg::SIA_MODE_POSITION, 10'h108, 3'h5);
		st(sia_pkg::SIA_MODE_SPEED, 10'h100, 3'h1);
		pw(0);
		fi(1, 7'h21, 7'h21);
		fi(0, 7'h12, 7'h12);
		ed(sia_pkg::IDX_IN_A, 16'h2151);
		ed(sia_pkg::IDX_IN_B, 16'h6043);
		pw(1);
		fi(1, 7'h20, 7'h01);
		`CHK("monitor", {2'h0, 7'h01, 7'h20}, inputStateMonitor_r)
		@(negedge sys_clk);
		paramRdIdx = sia_pkg::IDX_MON_IN;
		@(negedge sys_clk);
		`CHK("monitor slot", 16'h00A0, paramRdData_r)
		fi(0, 7'h01, 7'h20);
		ed(sia_pkg::IDX_IN_B, 16'h6987);
		pw(1);
		fi(1, 7'h00, 7'h28);
		fi(1, 7'h01, 7'h08);
		ed(sia_pkg::IDX_POL, 16'h0110);
		pw(1);
		st(sia_pkg::SIA_MODE_POSITION, 10'h000, 3'h6);
		st(sia_pkg::SIA_MODE_POSITION, 10'h008, 3'h2);
		conclude;
	end
endmodule

bind sia_allocator sia_allocator_monitor #(.FLASH_CYCLES(FLASH_CYCLES)) mon (.sys_clk, .sys_rst, .paramEdit,
	.paramRdIdx, .paramRdData_r, .saveFlash_r, .inTermPin, .sinkWiring, .inFunc_r, .inputStateMonitor_r,
	.statusIn, .ctrlMode, .outTerm_r);
